//--- rtl/stw_timer.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "stw_params.svh"

// Behaviour
// R1: debug halt stops the timer unless halt_run_override is one.
// R2: bottom is zero, max all ones, top the sequence's highest value.
// R3: update condition raised at bottom or top, chosen by count direction.
// R4: enable bit starts counting at the prescale_select tick rate.
// R5: count_event_input_enable makes event inputs advance the counter.
// R6: direction from count_sense_down; counting up wraps to zero after top.
// R7: counting down from bottom reloads top: the wrap limit, or channel zero's compare in frequency mode.
// R8: tally_value write is immediate and beats count, clear, reload.
// R9: direction may change while running without disabling.
// R10: wrap limit and each compare value own a buffer and valid flag.
// R11: buffer write sets valid; update copies buffer and clears valid.
// R12: active and buffer compare registers both writable; direct bypasses.
// R13: unbuffered limit write immediate; limit below count runs to max.
// R14: buffered active limit changes only on the update condition.
// R15: continuous compare; match sets channel flag next timer cycle.
// R16: compare buffer moves to active only on update condition.
// R17: pin overridden only in wave mode, counting ticks, channel enabled.
// R18: frequency mode toggles output on every match; period from compare.
// R19: compare zero without prescaling toggles at half the clock rate.
// R20: single slope: count bottom to top, set at top, clear on match.
// R21: limits from three up to all ones are supported.
// R22: single slope period is wrap limit plus one ticks.
// R23: prescaler gives one-cycle tick enable; counter moves only then.

module stw_timer #(
	parameter int NUM_CH = `STW_NUM_CH,
	parameter int PRESC_W = `STW_PRESC_W
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`STW_ADDR_W-1:0] PADDR,
	input wire logic [`STW_DATA_W-1:0] PWDATA,
	output logic [`STW_DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic DEBUG_HALT,
	input wire logic EVENT_IN,
	output logic [NUM_CH-1:0] WAVE_PIN_OUT,
	output logic [NUM_CH-1:0] WAVE_PIN_OVR,
	output logic [NUM_CH-1:0] MATCH_IRQ
);

	generate
		if (NUM_CH < 1 || NUM_CH > `STW_MAX_CH) begin : g_bad_ch
			$error("channel count outside the register map");
		end
	endgenerate

	localparam stw_pkg::stw_top_t TOP_RST = '{
		tally: `STW_TALLY_RST,
		limit: `STW_LIMIT_RST,
		limit_buf: `STW_LIMIT_RST,
		default: '0
	};

	stw_pkg::stw_top_t s_reg;
	stw_pkg::stw_top_t s_next;

	stw_pkg::stw_wave_t wave_mode;
	logic setup_ph;
	logic wr_acc;
	logic halted;
	logic run;
	logic presc_tick;
	logic ev_rise;
	logic tick;
	logic [`STW_TALLY_W-1:0] top_value;
	logic at_top;
	logic at_bottom;
	logic at_max;
	logic update;
	logic wr_tally;
	logic wr_limit;
	logic wr_limit_buf;
	logic [`STW_TALLY_W-1:0] wdata16;
	logic [`STW_DATA_W-1:0] rd_data;
	logic rd_hit;
	logic [NUM_CH-1:0] wr_value;
	logic [NUM_CH-1:0] wr_buffer;
	logic [NUM_CH-1:0] flag_clr;
	logic [NUM_CH-1:0][`STW_TALLY_W-1:0] ch_value;
	logic [NUM_CH-1:0][`STW_TALLY_W-1:0] ch_buffer;
	logic [NUM_CH-1:0] ch_valid;
	logic [NUM_CH-1:0] ch_flag;
	logic [NUM_CH-1:0] ch_wave;

	// apb: zero wait states, read data latched in the setup cycle
	assign setup_ph = PSEL && !PENABLE;
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign wdata16 = PWDATA[`STW_TALLY_W-1:0];
	assign wr_tally = wr_acc && (PADDR == `STW_OFS_TALLY_VALUE);
	assign wr_limit = wr_acc && (PADDR == `STW_OFS_WRAP_LIMIT);
	assign wr_limit_buf = wr_acc && (PADDR == `STW_OFS_LIMIT_BUFFER);

	// raw mode field may hold unused codes; treat them as plain counting
	always_comb begin
		unique case (s_reg.wave_sel)
			3'h1: wave_mode = stw_pkg::STW_WAVE_FREQ;
			3'h3: wave_mode = stw_pkg::STW_WAVE_SINGLE;
			default: wave_mode = stw_pkg::STW_WAVE_NORMAL;
		endcase
	end

	assign halted = DEBUG_HALT && !s_reg.halt_run; // [R1]
	assign run = s_reg.enable && !halted; // [R4] [R1]
	assign ev_rise = EVENT_IN && !s_reg.event_prev;
	// events only counted on rising edges; prescaler unused then
	assign tick = s_reg.cnt_event ? (run && ev_rise) : presc_tick; // [R5] [R23]

	// frequency mode takes its period from channel zero's compare value
	assign top_value = (wave_mode == stw_pkg::STW_WAVE_FREQ) ? ch_value[0] : s_reg.limit; // [R18]
	assign at_top = (s_reg.tally == top_value); // [R2]
	assign at_bottom = (s_reg.tally == `STW_TALLY_RST); // [R2]
	assign at_max = (s_reg.tally == `STW_LIMIT_RST); // [R2]
	// no dual-slope mode here, so every mode updates at the wrap point
	assign update = tick && (s_reg.count_down ? at_bottom : at_top); // [R3]

	stw_prescaler #(
		.PRESC_W(PRESC_W)
	) u_presc (
		.clk(CLK_SYS),
		.rstn(RSTN),
		.run(run && !s_reg.cnt_event),
		.sel(s_reg.presc_sel),
		.tick(presc_tick)
	);

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			localparam logic [`STW_ADDR_W-1:0] CH_OFS = `STW_ADDR_W'(ch * 4);
			assign wr_value[ch] = wr_acc && (PADDR == `STW_OFS_MATCH_VALUE_BASE + CH_OFS); // [R12]
			assign wr_buffer[ch] = wr_acc && (PADDR == `STW_OFS_MATCH_BUFFER_BASE + CH_OFS); // [R12]
			assign flag_clr[ch] = wr_acc && (PADDR == `STW_OFS_MATCH_FLAGS) && PWDATA[ch];
			// pin taken only in a wave mode, on clock ticks, channel enabled
			assign WAVE_PIN_OVR[ch] = (wave_mode != stw_pkg::STW_WAVE_NORMAL)
				&& !s_reg.cnt_event && s_reg.chan_en[ch]; // [R17]
			assign MATCH_IRQ[ch] = ch_flag[ch] && s_reg.irq_en[ch]; // [R15]
			stw_channel u_ch (
				.clk(CLK_SYS),
				.rstn(RSTN),
				.tally(s_reg.tally),
				.tick(tick),
				.at_top(at_top),
				.update(update),
				.wave_mode(wave_mode),
				.wr_value(wr_value[ch]),
				.wr_buffer(wr_buffer[ch]),
				.wdata(wdata16),
				.flag_clr(flag_clr[ch]),
				.value(ch_value[ch]),
				.buffer(ch_buffer[ch]),
				.valid(ch_valid[ch]),
				.flag(ch_flag[ch]),
				.wave(ch_wave[ch])
			);
		end
	endgenerate

	// read decode; unmapped or misaligned addresses answer with an error
	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		unique case (PADDR)
			`STW_OFS_CONTROL_A: begin
				rd_data[`STW_A_ENABLE_BIT] = s_reg.enable;
				rd_data[`STW_A_PRESC_MSB:`STW_A_PRESC_LSB] = s_reg.presc_sel;
			end
			`STW_OFS_CONTROL_B: begin
				rd_data[`STW_B_WAVE_MSB:`STW_B_WAVE_LSB] = s_reg.wave_sel;
				rd_data[`STW_B_CHEN_LSB +: NUM_CH] = s_reg.chan_en[NUM_CH-1:0];
			end
			`STW_OFS_CONTROL_E: begin
				rd_data[`STW_E_DOWN_BIT] = s_reg.count_down;
			end
			`STW_OFS_CONTROL_F: begin
				rd_data[`STW_F_LIMIT_BV_BIT] = s_reg.limit_valid; // [R10]
				rd_data[`STW_F_MATCH_BV_LSB +: NUM_CH] = ch_valid; // [R10]
			end
			`STW_OFS_EVENT_CONTROL: begin
				rd_data[`STW_EV_COUNT_EVENT_INPUT_ENABLE_BIT] = s_reg.cnt_event;
			end
			`STW_OFS_HALT_CONTROL: begin
				rd_data[`STW_HALT_RUN_BIT] = s_reg.halt_run;
			end
			`STW_OFS_MATCH_IRQ_EN: begin
				rd_data[NUM_CH-1:0] = s_reg.irq_en[NUM_CH-1:0];
			end
			`STW_OFS_MATCH_FLAGS: begin
				rd_data[NUM_CH-1:0] = ch_flag;
			end
			`STW_OFS_TALLY_VALUE: begin
				rd_data[`STW_TALLY_W-1:0] = s_reg.tally;
			end
			`STW_OFS_WRAP_LIMIT: begin
				rd_data[`STW_TALLY_W-1:0] = s_reg.limit;
			end
			`STW_OFS_LIMIT_BUFFER: begin
				rd_data[`STW_TALLY_W-1:0] = s_reg.limit_buf;
			end
			default: begin
				rd_hit = 1'b0;
				for (int i = 0; i < NUM_CH; i++) begin
					if (PADDR == `STW_OFS_MATCH_VALUE_BASE + `STW_ADDR_W'(i * 4)) begin
						rd_data[`STW_TALLY_W-1:0] = ch_value[i];
						rd_hit = 1'b1;
					end
					if (PADDR == `STW_OFS_MATCH_BUFFER_BASE + `STW_ADDR_W'(i * 4)) begin
						rd_data[`STW_TALLY_W-1:0] = ch_buffer[i];
						rd_hit = 1'b1;
					end
				end
			end
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.event_prev = EVENT_IN;
		if (setup_ph) begin
			s_next.prdata = PWRITE ? '0 : rd_data;
			s_next.pslverr = !rd_hit;
		end

		// control writes
		if (wr_acc) begin
			unique case (PADDR)
				`STW_OFS_CONTROL_A: begin
					s_next.enable = PWDATA[`STW_A_ENABLE_BIT]; // [R4]
					s_next.presc_sel = PWDATA[`STW_A_PRESC_MSB:`STW_A_PRESC_LSB]; // [R4]
				end
				`STW_OFS_CONTROL_B: begin
					s_next.wave_sel = PWDATA[`STW_B_WAVE_MSB:`STW_B_WAVE_LSB];
					s_next.chan_en = PWDATA[`STW_B_CHEN_LSB +: `STW_MAX_CH];
				end
				`STW_OFS_CONTROL_E: begin
					s_next.count_down = PWDATA[`STW_E_DOWN_BIT]; // [R9]
				end
				`STW_OFS_EVENT_CONTROL: begin
					s_next.cnt_event = PWDATA[`STW_EV_COUNT_EVENT_INPUT_ENABLE_BIT]; // [R5]
				end
				`STW_OFS_HALT_CONTROL: begin
					s_next.halt_run = PWDATA[`STW_HALT_RUN_BIT]; // [R1]
				end
				`STW_OFS_MATCH_IRQ_EN: begin
					s_next.irq_en = PWDATA[`STW_MAX_CH-1:0];
				end
				default: begin
				end
			endcase
		end

		// counter: count, wrap or reload on a tick
		if (tick) begin
			if (s_reg.count_down) begin
				if (at_bottom) begin
					s_next.tally = top_value; // [R7]
				end else begin
					s_next.tally = s_reg.tally - 1'b1; // [R6]
				end
			end else begin
				// a limit below the count never matches, so it rolls past max
				if (at_top || at_max) begin
					s_next.tally = `STW_TALLY_RST; // [R6] [R13] [R22]
				end else begin
					s_next.tally = s_reg.tally + 1'b1; // [R6]
				end
			end
		end
		// software write last so it wins over any count activity
		if (wr_tally) begin
			s_next.tally = wdata16; // [R8]
		end

		// wrap limit double buffering
		if (update && s_reg.limit_valid) begin
			s_next.limit = s_reg.limit_buf; // [R14] [R11]
			s_next.limit_valid = 1'b0; // [R11]
		end
		if (wr_limit_buf) begin
			s_next.limit_buf = wdata16;
			s_next.limit_valid = 1'b1; // [R10] [R11]
		end
		// any 16-bit limit accepted, three through all ones included
		if (wr_limit) begin
			s_next.limit = wdata16; // [R13] [R21]
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			s_reg <= TOP_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign PRDATA = s_reg.prdata;
	assign PSLVERR = s_reg.pslverr;
	assign PREADY = 1'b1;
	assign WAVE_PIN_OUT = ch_wave;

endmodule : stw_timer

//--- rtl/stw_params.svh
`ifndef STW_PARAMS_SVH
`define STW_PARAMS_SVH

// widths and counts
`define STW_ADDR_W 12
`define STW_DATA_W 32
`define STW_TALLY_W 16
`define STW_MAX_CH 3
`define STW_NUM_CH 3
`define STW_PRESC_W 7
`define STW_SEL_W 3

// register byte offsets
`define STW_OFS_CONTROL_A 12'h000
`define STW_OFS_CONTROL_B 12'h004
`define STW_OFS_CONTROL_E 12'h008
`define STW_OFS_CONTROL_F 12'h00c
`define STW_OFS_EVENT_CONTROL 12'h010
`define STW_OFS_HALT_CONTROL 12'h014
`define STW_OFS_MATCH_IRQ_EN 12'h018
`define STW_OFS_MATCH_FLAGS 12'h01c
`define STW_OFS_TALLY_VALUE 12'h020
`define STW_OFS_WRAP_LIMIT 12'h024
`define STW_OFS_LIMIT_BUFFER 12'h028
`define STW_OFS_MATCH_VALUE_BASE 12'h030
`define STW_OFS_MATCH_BUFFER_BASE 12'h040
`define STW_OFS_CH_STRIDE 12'h004

// field positions
`define STW_A_ENABLE_BIT 0
`define STW_A_PRESC_LSB 1
`define STW_A_PRESC_MSB 3
`define STW_B_WAVE_LSB 0
`define STW_B_WAVE_MSB 2
`define STW_B_CHEN_LSB 4
`define STW_E_DOWN_BIT 0
`define STW_F_LIMIT_BV_BIT 0
`define STW_F_MATCH_BV_LSB 1
`define STW_EV_COUNT_EVENT_INPUT_ENABLE_BIT 0
`define STW_HALT_RUN_BIT 0

// reset values
`define STW_LIMIT_RST 16'hffff
`define STW_TALLY_RST 16'h0000
`define STW_MATCH_RST 16'h0000

`endif

//--- rtl/stw_pkg.sv
`include "stw_params.svh"

package stw_pkg;

	typedef enum logic [`STW_SEL_W-1:0] {
		STW_WAVE_NORMAL = 3'h0,
		STW_WAVE_FREQ = 3'h1,
		STW_WAVE_SINGLE = 3'h3
	} stw_wave_t;

	typedef struct packed {
		logic [`STW_TALLY_W-1:0] value;
		logic [`STW_TALLY_W-1:0] buffer;
		logic valid;
		logic flag;
		logic wave;
	} stw_chan_t;

	typedef struct packed {
		logic enable;
		logic [`STW_SEL_W-1:0] presc_sel;
		logic [`STW_SEL_W-1:0] wave_sel;
		logic [`STW_MAX_CH-1:0] chan_en;
		logic count_down;
		logic cnt_event;
		logic halt_run;
		logic [`STW_MAX_CH-1:0] irq_en;
		logic [`STW_TALLY_W-1:0] tally;
		logic [`STW_TALLY_W-1:0] limit;
		logic [`STW_TALLY_W-1:0] limit_buf;
		logic limit_valid;
		logic event_prev;
		logic [`STW_DATA_W-1:0] prdata;
		logic pslverr;
	} stw_top_t;

	typedef struct packed {
		logic [`STW_PRESC_W-1:0] count;
	} stw_presc_t;

endpackage : stw_pkg

//--- rtl/stw_prescaler.sv
`timescale 1ns/100ps
`include "stw_params.svh"

module stw_prescaler #(
	parameter int PRESC_W = `STW_PRESC_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic run,
	input wire logic [`STW_SEL_W-1:0] sel,
	output logic tick
);

	generate
		if (PRESC_W < 7) begin : g_bad_width
			$error("prescaler too narrow for the largest divider");
		end
	endgenerate

	stw_pkg::stw_presc_t s_reg;
	stw_pkg::stw_presc_t s_next;
	logic [PRESC_W-1:0] mask;

	// divider is two to the power of sel; counter restarts while stopped
	always_comb begin
		for (int i = 0; i < PRESC_W; i++) begin
			mask[i] = (i < int'(sel));
		end
		tick = run && ((s_reg.count & mask) == mask); // [R23]
		s_next = s_reg;
		if (run) begin
			s_next.count = s_reg.count + 1'b1;
		end else begin
			s_next.count = '0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule : stw_prescaler

//--- rtl/stw_channel.sv
`timescale 1ns/100ps
`include "stw_params.svh"

module stw_channel (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [`STW_TALLY_W-1:0] tally,
	input wire logic tick,
	input wire logic at_top,
	input wire logic update,
	input wire stw_pkg::stw_wave_t wave_mode,
	input wire logic wr_value,
	input wire logic wr_buffer,
	input wire logic [`STW_TALLY_W-1:0] wdata,
	input wire logic flag_clr,
	output logic [`STW_TALLY_W-1:0] value,
	output logic [`STW_TALLY_W-1:0] buffer,
	output logic valid,
	output logic flag,
	output logic wave
);

	localparam stw_pkg::stw_chan_t CH_RST = '{
		value: `STW_MATCH_RST,
		buffer: `STW_MATCH_RST,
		default: '0
	};

	stw_pkg::stw_chan_t s_reg;
	stw_pkg::stw_chan_t s_next;
	logic match;

	always_comb begin
		match = (tally == s_reg.value); // [R15]
		s_next = s_reg;
		if (update && s_reg.valid) begin
			s_next.value = s_reg.buffer; // [R16] [R11]
			s_next.valid = 1'b0; // [R11]
		end
		if (wr_buffer) begin
			s_next.buffer = wdata;
			s_next.valid = 1'b1; // [R10] [R11]
		end
		// direct write beats a buffer copy in the same cycle
		if (wr_value) begin
			s_next.value = wdata; // [R12]
		end
		if (flag_clr) begin
			s_next.flag = 1'b0;
		end
		// set wins over a clear arriving together
		if (tick && match) begin
			s_next.flag = 1'b1; // [R15]
		end
		unique case (wave_mode)
			stw_pkg::STW_WAVE_NORMAL: begin
				s_next.wave = 1'b0;
			end
			stw_pkg::STW_WAVE_FREQ: begin
				if (tick && match) begin
					s_next.wave = ~s_reg.wave; // [R18] [R19]
				end
			end
			stw_pkg::STW_WAVE_SINGLE: begin
				if (tick && match) begin
					s_next.wave = 1'b0; // [R20]
				end else if (tick && at_top) begin
					s_next.wave = 1'b1; // [R20]
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= CH_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign value = s_reg.value;
	assign buffer = s_reg.buffer;
	assign valid = s_reg.valid;
	assign flag = s_reg.flag;
	assign wave = s_reg.wave;

endmodule : stw_channel

//--- bench/stw_pin_model.sv
`timescale 1ns/100ps

module stw_pin_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ev_on,
	output logic ev,
	output int rises
);
	// one rise every two cycles while asked; line falls back low when idle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ev <= 1'b0;
			rises <= 0;
		end else begin
			ev <= ev_on & ~ev;
			if (ev_on & ~ev) begin
				rises <= rises + 1;
			end
		end
	end
endmodule : stw_pin_model

//--- bench/stw_timer_monitor.sv
`timescale 1ns/100ps

module stw_timer_monitor #(
	parameter int NUM_CH = 3
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PSLVERR,
	input wire logic [NUM_CH-1:0] WAVE_PIN_OUT,
	input wire logic [NUM_CH-1:0] WAVE_PIN_OVR,
	input wire logic [NUM_CH-1:0] MATCH_IRQ
);
	logic [2:0] wsel;
	logic [NUM_CH-1:0] chen;
	logic [NUM_CH-1:0] ien;
	logic cev;
	wire acc = PSEL && PENABLE;
	wire norm = wsel != 3'h1 && wsel != 3'h3;
	// shadow of written control bits, so pin checks need no internal probes
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			wsel <= 3'h0;
			chen <= '0;
			ien <= '0;
			cev <= 1'b0;
		end else if (acc && PWRITE) begin
			case (PADDR)
				12'h004: begin
					wsel <= PWDATA[2:0];
					chen <= PWDATA[4+:NUM_CH];
				end
				12'h010: cev <= PWDATA[0];
				12'h018: ien <= PWDATA[NUM_CH-1:0];
				default: ;
			endcase
		end
	end
	function automatic logic ok(logic [11:0] a);
		return a[1:0] == 2'h0 && (a <= 12'h028 || (a >= 12'h030 && a < 12'h030 + 4 * NUM_CH)
			|| (a >= 12'h040 && a < 12'h040 + 4 * NUM_CH));
	endfunction : ok
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	a_unmapped_err: assert property (acc && !ok(PADDR) |-> PSLVERR)
		else $error("no error on unmapped access");
	a_mapped_ok: assert property (acc && ok(PADDR) |-> !PSLVERR)
		else $error("error on mapped access");
	a_upper_zero: assert property (acc && !PWRITE |-> PRDATA[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_control_b_read: assert property (acc && !PWRITE && PADDR == 12'h004 |->
		PRDATA == ((32'(chen) << 4) | 32'(wsel))) else $error("control_b readback");
	a_pin_override: assert property (WAVE_PIN_OVR == ({NUM_CH{!norm && !cev}} & chen))
		else $error("pin override wrong");
	a_irq_masked: assert property ((MATCH_IRQ & ~ien) == '0)
		else $error("masked irq raised");
	a_normal_quiet: assert property (norm && $past(norm) |-> WAVE_PIN_OUT == '0)
		else $error("wave active in normal mode");
	a_flag_sticky: assert property (!(acc && PWRITE && PADDR inside {12'h018, 12'h01c})
		|=> (MATCH_IRQ & $past(MATCH_IRQ)) == $past(MATCH_IRQ)) else $error("flag lost");
	c_slverr: cover property (acc && PSLVERR);
	c_irq: cover property (|MATCH_IRQ);
	c_wave: cover property ($rose(WAVE_PIN_OUT[0]));
endmodule : stw_timer_monitor

bind stw_timer stw_timer_monitor #(.NUM_CH(NUM_CH)) u_mon (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PSLVERR(PSLVERR), .WAVE_PIN_OUT(WAVE_PIN_OUT),
	.WAVE_PIN_OVR(WAVE_PIN_OVR), .MATCH_IRQ(MATCH_IRQ));

//--- bench/tb_sixteen_bit_timer_waveform.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end

module tb_sixteen_bit_timer_waveform;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic halt = 1'b0;
	logic ev_on = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [31:0] rd;
	logic [31:0] prdata;
	logic pready;
	logic perr;
	logic ev;
	logic [2:0] wout;
	logic [2:0] irq;
	int fail_count = 0;
	int checked = 0;
	int seed = 10210;
	int cyc = 0;
	int rises, r0, s, l, c, t, sel, g, h;
	always #5 clk = ~clk;
	stw_timer dut (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(pa), .PWDATA(pwd), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
		.DEBUG_HALT(halt), .EVENT_IN(ev), .WAVE_PIN_OUT(wout), .WAVE_PIN_OVR(), .MATCH_IRQ(irq));
	stw_pin_model pm (.clk(clk), .rstn(rstn), .ev_on(ev_on), .ev(ev), .rises(rises));
	task automatic end_of_test();
		if (fail_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : acc
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask : rchk
	// waits for level v on pin p, then returns how many cycles it lasts
	task automatic lvl(input int p, input logic v, output int n);
		#1;
		n = 0;
		while (wout[p] !== v && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		while (wout[p] === v && n < 5000) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : lvl
	function automatic logic [15:0] step(logic [15:0] v, logic dn, logic [15:0] top, int k);
		for (int i = 0; i < k; i++)
			v = dn ? (v == 16'h0 ? top : v - 16'h1) : (v == top ? 16'h0 : v + 16'h1);
		return v;
	endfunction : step
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rchk("limit", 12'h024, 32'hffff);
		rchk("lbuf", 12'h028, 32'hffff);
		rchk("hole", 12'h02c, 32'h0);
		l = 16 + {$random(seed)} % 32;
		wr(12'h024, l);
		wr(12'h000, 32'h1);
		for (int n = 0; n < 4; n++) begin
			s = n % 2;
			t = n == 0 ? l - 1 : n == 1 ? 1 : {$random(seed)} % l;
			wr(12'h008, s);
			wr(12'h020, t);
			rchk("tally", 12'h020, step(t, s, l, 1));
			rchk("tally", 12'h020, step(t, s, l, 4));
		end
		halt <= 1'b1;
		t = {$random(seed)} % l;
		wr(12'h020, t);
		rchk("halted", 12'h020, t);
		rchk("halted", 12'h020, t);
		wr(12'h014, 32'h1);
		wr(12'h020, t);
		rchk("halt_run_override", 12'h020, step(t, s, l, 1));
		halt <= 1'b0;
		wr(12'h014, 32'h0);
		// buffered limit: must hold until the count reaches bottom
		wr(12'h020, l);
		wr(12'h028, l + 8);
		rchk("lbv", 12'h00c, 32'h1);
		rchk("limit", 12'h024, l);
		repeat (l + 4) @(posedge clk);
		rchk("limit", 12'h024, l + 8);
		rchk("lbv", 12'h00c, 32'h0);
		wr(12'h000, 32'h0);
		wr(12'h008, 32'h0);
		for (int i = 0; i < 3; i++) begin
			c = i == 0 ? 0 : {$random(seed)} % 6;
			sel = i == 0 ? 0 : {$random(seed)} % 3;
			wr(12'h020, 32'h0);
			wr(12'h030, c);
			wr(12'h004, 32'h11);
			wr(12'h000, (sel << 1) | 1);
			lvl(0, 1'b0, g);
			lvl(0, 1'b1, h);
			`CHK("toggle", (c + 1) << sel, h)
			wr(12'h000, 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			l = i == 0 ? 3 : 3 + {$random(seed)} % 8;
			c = {$random(seed)} % l;
			sel = {$random(seed)} % 2;
			wr(12'h000, 32'h0);
			wr(12'h020, 32'h0);
			wr(12'h024, l);
			wr(12'h034, c);
			wr(12'h004, 32'h23);
			wr(12'h000, (sel << 1) | 1);
			lvl(1, 1'b0, g);
			lvl(1, 1'b1, h);
			lvl(1, 1'b0, g);
			`CHK("high", (c + 1) << sel, h)
			`CHK("period", (l + 1) << sel, h + g)
		end
		// counting events: pins must stay with the port
		wr(12'h024, 32'hffff);
		wr(12'h004, 32'h73);
		wr(12'h010, 32'h1);
		wr(12'h020, 32'h0);
		r0 = rises;
		ev_on <= 1'b1;
		repeat (20) @(posedge clk);
		ev_on <= 1'b0;
		repeat (3) @(posedge clk);
		rchk("events", 12'h020, 32'(rises - r0));
		wr(12'h010, 32'h0);
		wr(12'h018, 32'h7);
		wr(12'h024, 32'h9);
		wr(12'h020, 32'h0);
		wr(12'h038, 32'h4);
		// a full period at the divide-by-two prescale the loop may leave here, so every channel matches
		repeat (24) @(posedge clk);
		rchk("flags", 12'h01c, 32'h7);
		`CHK("irq", 3'h7, irq)
		wr(12'h000, 32'h0);
		wr(12'h01c, 32'h7);
		rchk("flags", 12'h01c, 32'h0);
		`CHK("irq", 3'h0, irq)
		wr(12'h048, 32'h2);
		rchk("cbv", 12'h00c, 32'h8);
		rchk("cmp2", 12'h038, 32'h4);
		wr(12'h000, 32'h1);
		repeat (14) @(posedge clk);
		rchk("cmp2", 12'h038, 32'h2);
		rchk("cbv", 12'h00c, 32'h0);
		end_of_test();
	end
endmodule : tb_sixteen_bit_timer_waveform
